// File: design/qenc_channel.sv
// Purpose: one encoder channel controller (device end)
// Assumes: tracks synchronous to SYS_CLK; four instances form the module
// Notes: response given one cycle after the telegram
`timescale 1ns/1ps
`include "qenc_consts.svh"
module qenc_channel (
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RESET_N,
  // link
  qenc_link_if.device     LINK,
  // encoder tracks, true and inverted
  input  wire logic       TRACK_A,
  input  wire logic       TRACK_B,
  input  wire logic       TRACK_C,
  input  wire logic       TRACK_A_INV,
  input  wire logic       TRACK_B_INV,
  input  wire logic       TRACK_C_INV,
  // straps and control
  input  wire logic [1:0] EVAL_STRAP,
  input  wire logic       COMPL_STRAP,
  input  wire logic [2:0] FILTER_CFG,
  input  wire logic       COUNT_DISABLE
);
  qenc_pkg::dev_state_type s_q;
  qenc_pkg::dev_state_type s_d;
  logic [1:0] ab_now;
  logic       c_now;
  logic       step;
  logic       up;
  logic       exec_ok;
  logic [7:0] status;
  logic [23:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // track qualification: complementary pair must disagree to count
  always_comb
  begin
    if (COMPL_STRAP)
    begin
      ab_now = {TRACK_A & ~TRACK_A_INV, TRACK_B & ~TRACK_B_INV};
      c_now  = TRACK_C & ~TRACK_C_INV;
    end
    else
    begin
      ab_now = {TRACK_A, TRACK_B};
      c_now  = TRACK_C;
    end
  end

  qenc_decoder u_dec (
    .ab_prev   (s_q.ab_prev),
    .ab_now    (ab_now),
    .eval_mode (EVAL_STRAP),
    .step      (step),
    .up        (up)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    exec_ok = LINK.ctrl[7:4] == `CTRL_EXEC_NIBBLE;
    status  = {1'b0, COMPL_STRAP, s_q.valid, FILTER_CFG, EVAL_STRAP};
    rd_word = 24'h000000;
    s_d = s_q;
    s_d.ab_prev   = ab_now;
    s_d.c_prev    = {s_q.c_prev[0], c_now};
    s_d.rsp_valid = 1'b0;
    if (step && !COUNT_DISABLE)
    begin
      s_d.count = up ? s_q.count + 24'h000001 : s_q.count - 24'h000001;
    end
    // first rising zero impulse while armed
    if (s_q.armed && c_now && !s_q.c_prev[0])
    begin
      s_d.capture = s_q.count;
      s_d.armed   = 1'b0;
      s_d.valid   = 1'b1;
    end
    if (LINK.req) // bits 7:4 unused
    begin
      if (LINK.byte0[`CMD_LOAD_COUNT_BIT] && exec_ok)
      begin
        s_d.count = {LINK.byte3, LINK.byte2, LINK.byte1};
      end
      if (LINK.byte0[`CMD_ARM_CAPTURE_BIT] && exec_ok)
      begin
        s_d.armed = 1'b1;
        s_d.valid = 1'b0;
      end
      case (LINK.byte0[1:0])
        2'h1:    rd_word = s_q.count;
        2'h2:    rd_word = s_q.capture;
        default: rd_word = 24'h000000;
      endcase
      s_d.rsp_valid = 1'b1;
      s_d.rsp_b0    = status;
      s_d.rsp_b1    = rd_word[7:0];
      s_d.rsp_b2    = rd_word[15:8];
      s_d.rsp_b3    = rd_word[23:16];
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign LINK.rsp_valid = s_q.rsp_valid;
  assign LINK.rsp_byte0 = s_q.rsp_b0;
  assign LINK.rsp_byte1 = s_q.rsp_b1;
  assign LINK.rsp_byte2 = s_q.rsp_b2;
  assign LINK.rsp_byte3 = s_q.rsp_b3;
endmodule // qenc_channel

// File: design/qenc_consts.svh
// Purpose: constants shared by both ends of the encoder channel link
// Assumes: one channel per controller; four are instanced by the system
// Notes: Contract list below
`ifndef QENC_CONSTS_SVH
`define QENC_CONSTS_SVH
`define CMD_READ_COUNT_BIT   0
`define CMD_READ_CAPTURE_BIT 1
`define CMD_LOAD_COUNT_BIT   2
`define CMD_ARM_CAPTURE_BIT  3
`define CTRL_EXEC_NIBBLE     4'h1
`define STAT_VALID_BIT       5
`define STAT_COMPL_BIT       6
`define COUNT_RESET          24'h000000
// master register offsets (APB byte addresses)
`define REG_CTRL    12'h000
`define REG_CMD     12'h004
`define REG_LOAD    12'h008
`define REG_STATUS  12'h00C
`define REG_DATA    12'h010
`define REG_ERR     32'hDEADBEEF
`endif

// File: design/qenc_pkg.sv
// Purpose: types for the encoder channel link
// Assumes: nothing
// Notes: none
package qenc_pkg;
  typedef enum logic [1:0] {EVAL_X1, EVAL_X2, EVAL_X4, EVAL_UNDEF} eval_type;
  typedef enum {M_IDLE, M_SEND, M_WAIT} mstate_type;
  typedef struct packed {
    logic [23:0] count;
    logic [23:0] capture;
    logic        armed;
    logic        valid;
    logic [1:0]  ab_prev;
    logic [1:0]  c_prev;
    logic        rsp_valid;
    logic [7:0]  rsp_b0;
    logic [7:0]  rsp_b1;
    logic [7:0]  rsp_b2;
    logic [7:0]  rsp_b3;
  } dev_state_type;
  typedef struct packed {
    mstate_type  st;
    logic        req;
    logic [7:0]  ctrl;
    logic [7:0]  cmd;
    logic [23:0] load;
    logic [31:0] rsp;
    logic        busy;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } mst_state_type;
endpackage

// File: design/qenc_link_if.sv
// Purpose: telegram link between ring master and one channel
// Assumes: one clock; req is a one-cycle pulse, rsp_valid one cycle
// Notes: ctrl is the telegram control byte
`timescale 1ns/1ps
interface qenc_link_if (input wire logic SYS_CLK);
  logic        req;
  logic [7:0]  ctrl;
  logic [7:0]  byte0;
  logic [7:0]  byte1;
  logic [7:0]  byte2;
  logic [7:0]  byte3;
  logic        rsp_valid;
  logic [7:0]  rsp_byte0;
  logic [7:0]  rsp_byte1;
  logic [7:0]  rsp_byte2;
  logic [7:0]  rsp_byte3;
  modport master (output req, ctrl, byte0, byte1, byte2, byte3,
                  input rsp_valid, rsp_byte0, rsp_byte1, rsp_byte2, rsp_byte3);
  modport device (input req, ctrl, byte0, byte1, byte2, byte3,
                  output rsp_valid, rsp_byte0, rsp_byte1, rsp_byte2, rsp_byte3);
endinterface

// File: design/qenc_decoder.sv
// Purpose: quadrature step decode with 1x/2x/4x evaluation
// Assumes: inputs already sampled in the clock domain
// Notes: combinational; step is one-cycle per counted edge
`timescale 1ns/1ps
`include "qenc_consts.svh"
module qenc_decoder (
  // tracks
  input  wire logic [1:0] ab_prev,
  input  wire logic [1:0] ab_now,
  input  wire logic [1:0] eval_mode,
  // result
  output logic            step,
  output logic            up
);
  logic a_rise;
  logic a_fall;
  logic b_edge;
  always_comb
  begin
    a_rise = ab_now[1] & ~ab_prev[1];
    a_fall = ~ab_now[1] & ab_prev[1];
    b_edge = ab_now[0] ^ ab_prev[0];
    // direction: A leading B counts up
    up     = (a_rise | a_fall) ? (ab_now[1] ^ ab_now[0]) : ~(ab_now[1] ^ ab_now[0]);
    case (qenc_pkg::eval_type'(eval_mode))
      // x1 counts once per cycle: an A edge while B is low
      qenc_pkg::EVAL_X1: step = (a_rise | a_fall) & ~ab_now[0];
      qenc_pkg::EVAL_X2: step = a_rise | a_fall;
      qenc_pkg::EVAL_X4: step = a_rise | a_fall | b_edge;
      default:           step = 1'b0;
    endcase
  end
endmodule // qenc_decoder

// File: design/qenc_master.sv
// Purpose: ring master end: APB registers drive telegrams
// Assumes: one channel per link; channel order set by software
// Notes: response returns one cycle after the telegram pulse
`timescale 1ns/1ps
`include "qenc_consts.svh"
module qenc_master (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // apb
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // link
  qenc_link_if.master      LINK
);
  qenc_pkg::mst_state_type s_q;
  qenc_pkg::mst_state_type s_d;
  logic setup;
  logic commit;

  always_comb
  begin
    setup  = PSEL && !PENABLE;
    // writes land only on the access edge that samples PREADY high
    commit = PSEL && PENABLE && PWRITE && s_q.pready;
    s_d = s_q;
    s_d.req     = 1'b0;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    if (setup)
    begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h00000000;
      case (PADDR)
        `REG_CTRL:   s_d.prdata = {24'h000000, s_q.ctrl};
        `REG_CMD:    s_d.prdata = {24'h000000, s_q.cmd};
        `REG_LOAD:   s_d.prdata = {8'h00, s_q.load};
        `REG_STATUS: s_d.prdata = {31'h00000000, s_q.busy};
        `REG_DATA:   s_d.prdata = s_q.rsp; // software checks bit 5
        default:     s_d.pslverr = 1'b1;
      endcase
    end
    if (commit)
    begin
      case (PADDR)
        `REG_CTRL: s_d.ctrl = PWDATA[7:0];
        `REG_CMD:
        begin
          if (!s_q.busy)
          begin
            s_d.cmd  = PWDATA[7:0];
            s_d.busy = 1'b1;
            s_d.st   = qenc_pkg::M_SEND;
          end
        end
        `REG_LOAD: s_d.load = PWDATA[23:0];
        default:   s_d.ctrl = s_q.ctrl;
      endcase
    end
    case (s_q.st)
      // idle keeps any launch decided above
      qenc_pkg::M_IDLE: s_d.req = 1'b0;
      qenc_pkg::M_SEND:
      begin
        s_d.req = 1'b1;
        s_d.st  = qenc_pkg::M_WAIT;
      end
      qenc_pkg::M_WAIT:
        if (LINK.rsp_valid)
        begin
          s_d.rsp  = {LINK.rsp_byte3, LINK.rsp_byte2, LINK.rsp_byte1, LINK.rsp_byte0};
          s_d.busy = 1'b0;
          s_d.st   = qenc_pkg::M_IDLE;
        end
      default: s_d.st = qenc_pkg::M_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      s_q <= '{st: qenc_pkg::M_IDLE, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign PREADY     = s_q.pready;
  assign PRDATA     = s_q.prdata;
  assign PSLVERR    = s_q.pslverr;
  assign LINK.req   = s_q.req;
  assign LINK.ctrl  = s_q.ctrl;
  assign LINK.byte0 = s_q.cmd;
  assign LINK.byte1 = s_q.load[7:0];
  assign LINK.byte2 = s_q.load[15:8];
  assign LINK.byte3 = s_q.load[23:16];
endmodule // qenc_master

// File: bench/qenc_link_asserts.sv
// Purpose: link checks between master and channel
// Assumes: one clock, sync active-low reset
// Notes: capture tracked from read replies
`timescale 1ns/1ps
module qenc_link_asserts (
  // clock and reset
  input wire logic       SYS_CLK,
  input wire logic       RESET_N,
  // link
  input wire logic       req,
  input wire logic [7:0] ctrl,
  input wire logic [7:0] byte0,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_byte0,
  input wire logic [7:0] rsp_byte1,
  input wire logic [7:0] rsp_byte2,
  input wire logic [7:0] rsp_byte3
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  logic [7:0]  cmd_q;
  logic [23:0] cap_q;
  logic        ok_q;
  wire  [23:0] val = {rsp_byte3, rsp_byte2, rsp_byte1};
  wire         cap_rd = rsp_valid && cmd_q[1:0] == 2'b10 && rsp_byte0[5];
  ////////////////////////////////////////////////////////////////
  // remember the last valid capture reply
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      cmd_q <= 8'h00;
      ok_q <= 1'b0;
      cap_q <= 24'h000000;
    end
    else
    begin
      if (req) cmd_q <= byte0;
      if (req && ctrl[7:4] == 4'h1 && byte0[3]) ok_q <= 1'b0;
      else if (cap_rd)
      begin
        ok_q <= 1'b1;
        cap_q <= val;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  a_rsp_next:
    assert property (req |=> rsp_valid) else $error("no reply after telegram");
  a_rsp_cause:
    assert property (rsp_valid |-> $past(req)) else $error("reply without telegram");
  a_rsp_pulse:
    assert property (rsp_valid |=> !rsp_valid) else $error("reply pulse too long");
  a_req_pulse:
    assert property (req |=> !req) else $error("telegram pulse too long");
  a_req_hold:
    assert property (req |=> $stable({ctrl, byte0, byte1, byte2, byte3}))
      else $error("telegram bytes moved");
  a_dual_read:
    assert property (req && byte0[1:0] == 2'b11 |=> val == 24'h000000)
      else $error("value returned on double read");
  a_stat_rsv:
    assert property (rsp_valid |-> !rsp_byte0[7]) else $error("reserved status set");
  a_rsp_hold:
    assert property (!rsp_valid |-> $stable({rsp_byte0, val})) else $error("reply moved");
  a_cap_kept:
    assert property (cap_rd && ok_q |-> val == cap_q) else $error("capture changed");
endmodule // qenc_link_asserts

// File: bench/tb_quad_encoder_counter_cmd.sv
// Purpose: bench for master and channel joined over the link
// Assumes: APB reply in access phase, link reply one cycle on
// Notes: tracks stand still while telegrams run
`timescale 1ns/1ps
`include "qenc_consts.svh"
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin n_fail++; \
  $display("FAIL %0t got %h exp %h", $time, g, x); end end
module tb_quad_encoder_counter_cmd;
  logic        sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, d;
  logic        pready, pslverr, e, ta = 0, tb = 0, tc = 0, bad = 0, compl = 0, cdis = 0;
  logic [1:0]  eval = 2'b10;
  logic [2:0]  filt = 3'b101;
  int          n_fail = 0, cmp_count = 0, ph = 0;
  qenc_link_if qenc_link_if_inst (.SYS_CLK(sys_clk));
  qenc_master qenc_master_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .LINK(qenc_link_if_inst.master));
  qenc_channel qenc_channel_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .LINK(qenc_link_if_inst.device), .TRACK_A(ta), .TRACK_B(tb), .TRACK_C(tc),
    .TRACK_A_INV(~ta ^ bad), .TRACK_B_INV(~tb ^ bad), .TRACK_C_INV(~tc ^ bad),
    .EVAL_STRAP(eval), .COMPL_STRAP(compl), .FILTER_CFG(filt), .COUNT_DISABLE(cdis));
  qenc_link_asserts qenc_link_asserts_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .req(qenc_link_if_inst.req), .ctrl(qenc_link_if_inst.ctrl),
    .byte0(qenc_link_if_inst.byte0), .byte1(qenc_link_if_inst.byte1),
    .byte2(qenc_link_if_inst.byte2), .byte3(qenc_link_if_inst.byte3),
    .rsp_valid(qenc_link_if_inst.rsp_valid), .rsp_byte0(qenc_link_if_inst.rsp_byte0),
    .rsp_byte1(qenc_link_if_inst.rsp_byte1), .rsp_byte2(qenc_link_if_inst.rsp_byte2),
    .rsp_byte3(qenc_link_if_inst.rsp_byte3));
  initial forever #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] st(input logic v);
    return {1'b0, compl, v, filt, eval};
  endfunction
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic lim(input int n);
    if (n >= 50)
    begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    lim(n);
    d = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // one telegram; reply word lands in d
  task automatic tg(input logic [7:0] c, input logic [7:0] cm, input logic [23:0] ld);
    int n;
    apb(1, `REG_CTRL, {24'h0, c});
    apb(1, `REG_LOAD, {8'h0, ld});
    apb(1, `REG_CMD, {24'h0, cm});
    for (n = 0; n < 50; n++)
    begin
      apb(0, `REG_STATUS, 32'h0);
      if (d[0] === 1'b0) break;
    end
    lim(n);
    apb(0, `REG_DATA, 32'h0);
  endtask
  task automatic step(input int dir, input int k);
    logic [1:0] p [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
    repeat (k)
    begin
      ph = (ph + dir) & 3;
      @(posedge sys_clk);
      {ta, tb} <= p[ph];
      repeat (3) @(posedge sys_clk);
    end
  endtask
  task automatic zp();
    @(posedge sys_clk);
    tc <= 1;
    repeat (3) @(posedge sys_clk);
    tc <= 0;
    repeat (3) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_load();
    tg(8'h10, 8'h01, 24'h0);
    `CHK(d, {24'h000000, st(1'b0)})
    tg(8'h10, 8'h04, 24'h123456);
    `CHK(d[7:0], st(1'b0))
    tg(8'h20, 8'h04, 24'hABCDEF);
    tg(8'h30, 8'hF1, 24'h0);
    `CHK(d[31:8], 24'h123456)
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      @(posedge sys_clk);
      eval <= m[1:0];
      tg(8'h10, 8'h04, 24'h0);
      step(1, 4);
      tg(8'h10, 8'h01, 24'h0);
      `CHK(d, {m == 3 ? 24'h0 : 24'h1 << m, st(1'b0)})
    end
    @(posedge sys_clk);
    eval <= 2'b10;
    step(-1, 5);
    tg(8'h10, 8'h01, 24'h0);
    `CHK(d[31:8], 24'hFFFFFB)
    cdis <= 1;
    step(1, 3);
    tg(8'h10, 8'h01, 24'h0);
    `CHK(d[31:8], 24'hFFFFFB)
    cdis <= 0;
  endtask
  task automatic t_capture();
    tg(8'h10, 8'h0C, 24'h000010);
    tg(8'h10, 8'h02, 24'h0);
    `CHK(d[7:0], st(1'b0))
    zp();
    step(1, 4);
    zp();
    repeat (2)
    begin
      tg(8'h10, 8'h02, 24'h0);
      `CHK(d, {24'h000010, st(1'b1)})
    end
    tg(8'h20, 8'h0B, 24'h0);
    `CHK(d, {24'h000000, st(1'b1)})
    tg(8'h10, 8'h09, 24'h0);
    `CHK(d, {24'h000014, st(1'b1)})
    tg(8'h10, 8'h01, 24'h0);
    `CHK(d[7:0], st(1'b0))
  endtask
  task automatic t_compl();
    // both tracks low first, so the strap change itself makes no edge
    step(1, 2);
    @(posedge sys_clk);
    compl <= 1;
    bad <= 1;
    step(1, 4);
    tg(8'h10, 8'h01, 24'h0);
    `CHK(d, {24'h000016, st(1'b0)})
    bad <= 0;
    step(1, 4);
    tg(8'h10, 8'h01, 24'h0);
    `CHK(d[31:8], 24'h00001A)
    apb(0, 12'h100, 32'h0);
    `CHK(e, 1'b1)
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1;
    t_load();
    t_modes();
    t_capture();
    t_compl();
    wrap_up();
  end
endmodule // tb_quad_encoder_counter_cmd
